// file: rtl/nlx_crossbar.sv
/*
 * Node crossbar: four local banks, three outgoing network ports and the
 * register-file port, shared by five masters under fixed priority.
 * Assumes all masters run on ref_clk and hold a request until its ack.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nlx_defs.svh"

//
// Contract
// - Local memory is four separate banks, each eight bytes wide.
// - Every bank takes one access per cycle, four in total.
// - Banks do byte and double accesses; narrow writes touch only their lanes.
// - Fetch, load/store, DMA and network masters may all be active at once.
// - A fetch returns one aligned eight-byte block.
// - Fetches to non-local addresses go out through the network.
// - Load/store moves 8, 16, 32 or 64 bits locally or remotely.
// - DMA moves 8, 16, 32 or 64 bits with no CPU help.
// - Returned remote read data is an ordinary incoming write.
// - Conflicts resolve by fixed priority, never round-robin.
// - Banks: write net, read-request net, load/store, fetch, DMA.
// - Outgoing read-request port: load/store, fetch, DMA.
// - Write and off-chip ports: read-request replies, load/store, DMA.
// - Register file: write net, read-request net, load/store.
// - Top twelve address bits zero means local, else to the network.
module nlx_crossbar
    import nlx_pkg::*;
#(
    parameter int BANK_WORDS = `NLX_BANK_WORDS,
    parameter logic [11:0] OFFCHIP_ROW = `NLX_OFFCHIP_ROW
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire nlx_req_type req_wnet,
    input wire nlx_req_type req_rreq,
    input wire nlx_req_type req_ldst,
    input wire nlx_req_type req_fetch,
    input wire nlx_req_type req_dma,
    input wire logic [63:0] rf_rdata,
    output nlx_rsp_type rsp_wnet,
    output nlx_rsp_type rsp_rreq,
    output nlx_rsp_type rsp_ldst,
    output nlx_rsp_type rsp_fetch,
    output nlx_rsp_type rsp_dma,
    output nlx_req_type rd_req_out,
    output nlx_req_type wr_net_out,
    output nlx_req_type offchip_out,
    output nlx_req_type rf_cmd
);
    localparam int NM = 5;
    localparam int NR = 8;
    localparam int IW = $clog2(BANK_WORDS);

    // Index bits must stay below the bank select bits
    if (BANK_WORDS < 2 || BANK_WORDS > `NLX_BANK_WORDS ||
        (1 << IW) != BANK_WORDS) begin : g_chk
        $error("BANK_WORDS must be a power of two up to 1024");
    end

    typedef struct packed {
        nlx_rsp_type [NM-1:0] rsp;
        logic [NM-1:0] infl;
        logic resp_pend;
        logic [1:0] resp_size;
        logic [31:0] resp_addr;
        logic [63:0] resp_data;
        nlx_req_type rdout;
        nlx_req_type wrout;
        nlx_req_type offch;
        nlx_req_type rf;
    } nlx_state_type;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [NM-1:0] nlx_first(input logic [NM-1:0] v);
        return v & (~v + 5'h01);
    endfunction : nlx_first

    function automatic logic [7:0] nlx_be(input logic [1:0] sz,
                                          input logic [2:0] a);
        logic [7:0] m;
        case (sz)
            `NLX_SZ_BYTE: m = `NLX_BE_BYTE;
            `NLX_SZ_HALF: m = `NLX_BE_HALF;
            `NLX_SZ_WORD: m = `NLX_BE_WORD;
            default: m = `NLX_BE_DBL;
        endcase
        return m << a;
    endfunction : nlx_be

    // Narrow reads hand back only their own lanes, upper bytes zero
    function automatic logic [63:0] nlx_keep(input logic [1:0] sz);
        logic [7:0] b;
        logic [63:0] k;
        b = nlx_be(sz, 3'h0);
        k = '0;
        for (int i = 0; i < 8; i++) begin
            k[i*8 +: 8] = {8{b[i]}};
        end
        return k;
    endfunction : nlx_keep

    function automatic nlx_res_type nlx_route(input nlx_master_type m,
                                              input nlx_req_type q,
                                              input logic [11:0] offb);
        if (q.addr[`NLX_NODE_MSB:`NLX_NODE_LSB] == `NLX_NODE_LOCAL) begin
            if (q.addr[`NLX_MEM_MSB:`NLX_MEM_LSB] == '0) begin
                return nlx_res_type'({2'b00,
                    q.addr[`NLX_BANK_MSB:`NLX_BANK_LSB]});
            end
            if (q.addr[`NLX_RF_MSB:`NLX_RF_LSB] == `NLX_RF_REGION &&
                m != M_FETCH && m != M_DMA) begin
                return R_RF;
            end
            return R_NONE;
        end
        // Incoming traffic for another node is not ours to forward
        if (m == M_WNET || m == M_RREQ) begin
            return R_NONE;
        end
        if (!q.write) begin
            return R_RDOUT;
        end
        return (q.addr[`NLX_NODE_MSB:`NLX_NODE_LSB] >= offb) ?
            R_OFFCH : R_WROUT;
    endfunction : nlx_route

    // ------------------------------------------------------------------
    // Arbitration and datapath
    // ------------------------------------------------------------------
    nlx_state_type s_r;
    nlx_state_type s_nxt;
    nlx_req_type [NM-1:0] req;
    nlx_res_type [NM-1:0] res;
    logic [NM-1:0] elig;
    logic [NR-1:0][NM-1:0] gnt;
    logic [3:0] mem_we;
    logic [3:0][IW-1:0] mem_idx;
    logic [3:0][63:0] mem_wd;
    logic [3:0][7:0] mem_be;
    logic [63:0] mem [4][BANK_WORDS];
    nlx_res_type resp_res;
    logic [NM-1:0] vec;
    logic [63:0] rd;

    always_comb begin
        req = {req_dma, req_fetch, req_ldst, req_rreq, req_wnet};
        // Fetch is always an aligned double read
        req[M_FETCH].write = 1'b0;
        req[M_FETCH].size = `NLX_SZ_DBL;
        req[M_FETCH].addr[`NLX_LANE_MSB:0] = '0;
        s_nxt = s_r;
        mem_we = '0;
        mem_idx = '0;
        mem_wd = '0;
        mem_be = '0;
        gnt = '0;
        vec = '0;
        rd = '0;
        s_nxt.rdout.valid = 1'b0;
        s_nxt.wrout.valid = 1'b0;
        s_nxt.offch.valid = 1'b0;
        s_nxt.rf.valid = 1'b0;
        s_nxt.resp_pend = 1'b0;
        resp_res = (s_r.resp_addr[`NLX_NODE_MSB:`NLX_NODE_LSB] >=
            OFFCHIP_ROW) ? R_OFFCH : R_WROUT;
        for (int m = 0; m < NM; m++) begin
            s_nxt.rsp[m].ack = 1'b0;
            // Acked or in flight: old request is still on the wires
            elig[m] = req[m].valid && !s_r.rsp[m].ack && !s_r.infl[m];
            res[m] = nlx_route(nlx_master_type'(m), req[m], OFFCHIP_ROW);
            if (elig[m] && res[m] == R_NONE) begin
                s_nxt.rsp[m].ack = 1'b1;
                s_nxt.rsp[m].data = '0;
            end
            if (s_r.infl[m]) begin
                s_nxt.infl[m] = 1'b0;
                s_nxt.rsp[m].ack = 1'b1;
                rd = (rf_rdata >> {req[m].addr[`NLX_LANE_MSB:0], 3'b000}) &
                    nlx_keep(req[m].size);
                s_nxt.rsp[m].data = rd;
                if (m == M_RREQ && !req[m].write) begin
                    s_nxt.resp_pend = 1'b1;
                    s_nxt.resp_addr = req[m].data[31:0];
                    s_nxt.resp_size = req[m].size;
                    s_nxt.resp_data = rd;
                end
            end
        end
        // Pending reply owns its write port this cycle
        if (s_r.resp_pend) begin
            if (resp_res == R_OFFCH) begin
                s_nxt.offch = {1'b1, 1'b1, s_r.resp_size, s_r.resp_addr,
                    s_r.resp_data};
            end else begin
                s_nxt.wrout = {1'b1, 1'b1, s_r.resp_size, s_r.resp_addr,
                    s_r.resp_data};
            end
        end
        for (int r = 0; r < NR; r++) begin
            for (int m = 0; m < NM; m++) begin
                vec[m] = elig[m] && res[m] == nlx_res_type'(r);
            end
            if (s_r.resp_pend && resp_res == nlx_res_type'(r)) begin
                vec = '0;
            end
            gnt[r] = nlx_first(vec);
            for (int m = 0; m < NM; m++) begin
                if (gnt[r][m]) begin
                    s_nxt.rsp[m].ack = (r != int'(R_RF));
                    if (r <= int'(R_BANK3)) begin
                        mem_idx[r] = req[m].addr[`NLX_IDX_LSB +: IW];
                        if (req[m].write) begin
                            mem_we[r] = 1'b1;
                            mem_be[r] = nlx_be(req[m].size,
                                req[m].addr[`NLX_LANE_MSB:0]);
                            mem_wd[r] = req[m].data <<
                                {req[m].addr[`NLX_LANE_MSB:0], 3'b000};
                        end else begin
                            rd = (mem[r][mem_idx[r]] >>
                                {req[m].addr[`NLX_LANE_MSB:0], 3'b000}) &
                                nlx_keep(req[m].size);
                            s_nxt.rsp[m].data = rd;
                            if (m == int'(M_RREQ)) begin
                                s_nxt.resp_pend = 1'b1;
                                s_nxt.resp_addr = req[m].data[31:0];
                                s_nxt.resp_size = req[m].size;
                                s_nxt.resp_data = rd;
                            end
                        end
                    end else if (r == int'(R_RDOUT)) begin
                        s_nxt.rdout = req[m];
                    end else if (r == int'(R_WROUT)) begin
                        s_nxt.wrout = req[m];
                    end else if (r == int'(R_OFFCH)) begin
                        s_nxt.offch = req[m];
                    end else begin
                        // Register file answers while the command stands
                        s_nxt.rf = req[m];
                        s_nxt.infl[m] = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Storage has no reset; only written lanes change
    always_ff @(posedge ref_clk) begin
        for (int b = 0; b < 4; b++) begin
            for (int k = 0; k < 8; k++) begin
                if (mem_we[b] && mem_be[b][k]) begin
                    mem[b][mem_idx[b]][k*8 +: 8] <= mem_wd[b][k*8 +: 8];
                end
            end
        end
    end

    assign rsp_wnet = s_r.rsp[M_WNET];
    assign rsp_rreq = s_r.rsp[M_RREQ];
    assign rsp_ldst = s_r.rsp[M_LDST];
    assign rsp_fetch = s_r.rsp[M_FETCH];
    assign rsp_dma = s_r.rsp[M_DMA];
    assign rd_req_out = s_r.rdout;
    assign wr_net_out = s_r.wrout;
    assign offchip_out = s_r.offch;
    assign rf_cmd = s_r.rf;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic rreq_bank_rd;
    assign rreq_bank_rd = !req[M_RREQ].write &&
        |{gnt[0][M_RREQ], gnt[1][M_RREQ], gnt[2][M_RREQ], gnt[3][M_RREQ]};

    sequence seq_reply_taken;
        rreq_bank_rd;
    endsequence
    sequence seq_reply_sent;
        ##1 s_r.resp_pend ##1 (wr_net_out.valid || offchip_out.valid);
    endsequence

    a_one_grant: assert property ($onehot0(gnt[0]) && $onehot0(gnt[1]) &&
        $onehot0(gnt[2]) && $onehot0(gnt[3]) && $onehot0(gnt[4]) &&
        $onehot0(gnt[5]) && $onehot0(gnt[6]) && $onehot0(gnt[7]))
        else $error("two grants on one resource");
    a_wnet_bank_win: assert property (elig[M_WNET] && res[M_WNET] <= R_BANK3
        |=> rsp_wnet.ack) else $error("write net lost a bank");
    a_dma_bank_lose: assert property (elig[M_DMA] && elig[M_FETCH] &&
        res[M_DMA] == res[M_FETCH] && res[M_DMA] <= R_BANK3 &&
        !elig[M_WNET] && !elig[M_RREQ] && !elig[M_LDST]
        |=> rsp_fetch.ack && !rsp_dma.ack)
        else $error("dma beat fetch on a bank");
    a_loser_stalls: assert property (elig[M_LDST] && res[M_LDST] != R_NONE &&
        !(|gnt[res[M_LDST]][M_LDST]) |=> !rsp_ldst.ack)
        else $error("stalled load/store acked");
    a_rdout_order: assert property (elig[M_LDST] && elig[M_FETCH] &&
        res[M_LDST] == R_RDOUT && res[M_FETCH] == R_RDOUT
        |=> rd_req_out.valid && rd_req_out.addr == $past(req_ldst.addr))
        else $error("read port priority wrong");
    a_rf_order: assert property (elig[M_WNET] && elig[M_LDST] &&
        res[M_WNET] == R_RF && res[M_LDST] == R_RF
        |=> rf_cmd.valid && rf_cmd.addr == $past(req_wnet.addr)
        ##1 rsp_wnet.ack && !rsp_ldst.ack)
        else $error("register file priority wrong");
    a_reply_path: assert property (seq_reply_taken |-> seq_reply_sent)
        else $error("read reply not sent");
    a_remote_read: assert property (elig[M_DMA] && !req_dma.write &&
        req_dma.addr[`NLX_NODE_MSB:`NLX_NODE_LSB] != `NLX_NODE_LOCAL &&
        !elig[M_LDST] && !elig[M_FETCH] |=> rd_req_out.valid &&
        rd_req_out.addr == $past(req_dma.addr))
        else $error("remote read not forwarded");
    a_banks_parallel: assert property (elig[M_LDST] && elig[M_FETCH] &&
        res[M_LDST] <= R_BANK3 && res[M_FETCH] <= R_BANK3 &&
        res[M_LDST] != res[M_FETCH] && !elig[M_WNET] && !elig[M_RREQ]
        |=> rsp_ldst.ack && rsp_fetch.ack)
        else $error("banks not parallel");
endmodule : nlx_crossbar
`default_nettype wire

// file: rtl/nlx_defs.svh
/*
 * Address map, lane and size constants for the node crossbar.
 * Assumes 32-bit addresses with the node number in the top twelve bits.
 */
`ifndef NLX_DEFS_SVH
`define NLX_DEFS_SVH

`define NLX_NODE_MSB 31
`define NLX_NODE_LSB 20
`define NLX_NODE_LOCAL 12'h000
`define NLX_MEM_MSB 19
`define NLX_MEM_LSB 15
`define NLX_RF_MSB 19
`define NLX_RF_LSB 16
`define NLX_RF_REGION 4'hF
`define NLX_BANK_MSB 14
`define NLX_BANK_LSB 13
`define NLX_IDX_LSB 3
`define NLX_LANE_MSB 2
`define NLX_BANK_WORDS 1024
`define NLX_OFFCHIP_ROW 12'h800
`define NLX_SZ_BYTE 2'h0
`define NLX_SZ_HALF 2'h1
`define NLX_SZ_WORD 2'h2
`define NLX_SZ_DBL 2'h3
`define NLX_BE_BYTE 8'h01
`define NLX_BE_HALF 8'h03
`define NLX_BE_WORD 8'h0F
`define NLX_BE_DBL 8'hFF

`endif

// file: rtl/nlx_pkg.sv
/*
 * Types shared by the node crossbar: masters, resources, request and answer.
 * Assumes nothing beyond the constants header.
 */
package nlx_pkg;
    // Enum order is also arbitration order, highest first
    typedef enum logic [2:0] {M_WNET, M_RREQ, M_LDST, M_FETCH, M_DMA}
        nlx_master_type;
    typedef enum logic [3:0] {R_BANK0, R_BANK1, R_BANK2, R_BANK3, R_RDOUT,
        R_WROUT, R_OFFCH, R_RF, R_NONE} nlx_res_type;
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [63:0] data;
    } nlx_req_type;
    typedef struct packed {
        logic ack;
        logic [63:0] data;
    } nlx_rsp_type;
endpackage : nlx_pkg

// file: tb/nlx_rf_model.sv
/* Register-file model behind the crossbar's register port.
   Assumes rf_cmd is a registered one-cycle request on ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module nlx_rf_model
    import nlx_pkg::*;
(
    input wire logic ref_clk,
    input wire nlx_req_type rf_cmd,
    output logic [63:0] rf_rdata
);
    logic [63:0] regs_r [64];
    logic [5:0] idx;
    assign idx = rf_cmd.addr[8:3];
    // Unselected: inverted word, so a stale value never passes
    assign rf_rdata = rf_cmd.valid ? regs_r[idx] : ~regs_r[idx];
    always_ff @(posedge ref_clk) begin
        if (rf_cmd.valid && rf_cmd.write) begin
            regs_r[idx] <= rf_cmd.data;
        end
    end
endmodule : nlx_rf_model
`default_nettype wire

// file: tb/testbench.sv
/* Self-checking bench: five masters contend for banks and ports.
   Assumes the crossbar's one-cycle ack and hold-until-ack masters. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    import nlx_pkg::*;
    logic ref_clk;
    logic nrst;
    nlx_req_type rq [5];
    nlx_rsp_type rs [5];
    nlx_req_type rd_o, wr_o, off_o, rf_o;
    logic [63:0] rf_d;
    logic [63:0] got [5];
    int at [5];
    int num_errors = 0;
    int n_compared = 0;
    localparam logic [63:0] D = 64'h1122_3344_5566_7788;
    localparam logic [63:0] E = 64'hCAFE_0000_0000_BEEF;

    nlx_crossbar nlx_crossbar_i (.ref_clk(ref_clk), .nrst(nrst),
        .req_wnet(rq[0]), .req_rreq(rq[1]), .req_ldst(rq[2]),
        .req_fetch(rq[3]), .req_dma(rq[4]), .rf_rdata(rf_d),
        .rsp_wnet(rs[0]), .rsp_rreq(rs[1]), .rsp_ldst(rs[2]),
        .rsp_fetch(rs[3]), .rsp_dma(rs[4]), .rd_req_out(rd_o),
        .wr_net_out(wr_o), .offchip_out(off_o), .rf_cmd(rf_o));
    nlx_rf_model nlx_rf_model_i (.ref_clk(ref_clk), .rf_cmd(rf_o),
        .rf_rdata(rf_d));

    // ----------------------------------------
    // Master drivers
    // ----------------------------------------
    function automatic nlx_req_type mk(logic w, logic [1:0] s,
        logic [31:0] a, logic [63:0] d);
        return '{1'b1, w, s, a, d};
    endfunction : mk

    // Each master drops its request as soon as its ack shows
    task automatic run();
        for (int m = 0; m < 5; m++) at[m] = 0;
        for (int n = 1; n < 16; n++) begin
            @(posedge ref_clk);
            #1;
            for (int m = 0; m < 5; m++) begin
                if (rs[m].ack === 1'b1) begin
                    at[m] = n;
                    got[m] = rs[m].data;
                    rq[m] = '0;
                end
            end
        end
    endtask : run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_sizes();
        logic [63:0] m;
        rq[4] = mk(1'b1, `NLX_SZ_DBL, 32'h0000_2000, D);
        run();
        `CHK(at[4], 1)
        for (int s = 0; s < 4; s++) begin
            m = (s == 3) ? '1 : (64'h1 << (8 << s)) - 64'h1;
            rq[2] = mk(1'b0, 2'(s), 32'h0000_2000, '0);
            run();
            `CHK(got[2], D & m)
        end
        rq[2] = mk(1'b1, `NLX_SZ_BYTE, 32'h0000_2003, 64'hAB);
        run();
        rq[3] = mk(1'b0, `NLX_SZ_BYTE, 32'h0000_2005, '0);
        run();
        `CHK(got[3], 64'h1122_3344_AB66_7788)
        `CHK(at[3], 1)
        $display("done sizes");
    endtask : t_sizes

    task automatic t_bankprio();
        rq[0] = mk(1'b1, `NLX_SZ_DBL, 32'h0000_4008, E);
        rq[1] = mk(1'b0, `NLX_SZ_DBL, 32'h0000_4008, 64'h0050_0000);
        rq[2] = mk(1'b0, `NLX_SZ_DBL, 32'h0000_4008, '0);
        rq[3] = rq[2];
        rq[4] = rq[2];
        run();
        for (int m = 0; m < 5; m++) `CHK(at[m], m + 1)
        `CHK(got[2], E)
        `CHK(got[4], E)
        `CHK({wr_o.write, wr_o.addr, wr_o.data}, {1'b1, 32'h0050_0000, E})
        $display("done bank priority");
    endtask : t_bankprio

    task automatic t_parallel();
        rq[0] = mk(1'b1, `NLX_SZ_DBL, 32'h0000_0100, D);
        rq[2] = mk(1'b0, `NLX_SZ_DBL, 32'h0000_2000, '0);
        rq[3] = mk(1'b0, `NLX_SZ_DBL, 32'h0000_4008, '0);
        rq[4] = mk(1'b0, `NLX_SZ_DBL, 32'h0000_6000, '0);
        run();
        for (int m = 0; m < 5; m++) if (m != 1) `CHK(at[m], 1)
        `CHK(got[2], 64'h1122_3344_AB66_7788)
        `CHK(got[3], E)
        $display("done parallel banks");
    endtask : t_parallel

    task automatic t_ports();
        rq[2] = mk(1'b0, `NLX_SZ_WORD, 32'h0010_0000, '0);
        rq[3] = mk(1'b0, `NLX_SZ_DBL, 32'h0020_0008, '0);
        rq[4] = mk(1'b0, `NLX_SZ_HALF, 32'h0030_0010, '0);
        run();
        for (int m = 2; m < 5; m++) `CHK(at[m], m - 1)
        `CHK(rd_o.addr, 32'h0030_0010)
        rq[2] = mk(1'b1, `NLX_SZ_DBL, 32'h0010_0000, 64'h1);
        rq[4] = mk(1'b1, `NLX_SZ_DBL, 32'h0020_0000, 64'h2);
        run();
        `CHK(at[2], 1)
        `CHK(at[4], 2)
        `CHK({wr_o.addr, wr_o.data}, {32'h0020_0000, 64'h2})
        rq[2] = mk(1'b0, `NLX_SZ_DBL, 32'h0000_8000, '0);
        rq[4] = mk(1'b1, `NLX_SZ_DBL, 32'h8000_0008, 64'h3);
        run();
        `CHK(at[2], 1)
        `CHK(got[2], 64'h0)
        `CHK({off_o.addr, off_o.data}, {32'h8000_0008, 64'h3})
        $display("done network ports");
    endtask : t_ports

    task automatic t_rf();
        rq[0] = mk(1'b1, `NLX_SZ_DBL, 32'h000F_0008, E);
        rq[2] = mk(1'b0, `NLX_SZ_DBL, 32'h000F_0008, '0);
        run();
        `CHK(at[0], 2)
        `CHK(at[2] > at[0], 1'b1)
        `CHK(got[2], E)
        $display("done register file");
    endtask : t_rf

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        nrst = 1'b0;
        for (int m = 0; m < 5; m++) rq[m] = '0;
        repeat (12) @(posedge ref_clk);
        #1;
        `CHK({rd_o.valid, rs[2].ack, rf_o.valid}, 3'b000)
        nrst = 1'b1;
        @(posedge ref_clk);
        #1;
        t_sizes();
        t_bankprio();
        t_parallel();
        t_ports();
        t_rf();
        give_verdict();
    end

    // Runs take 208 cycles; the watchdog allows 2500
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
